// ---- cte_cfg.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the counter channel
// Assumes: not included by cte_pkg.sv; included by cte_counter_channel.sv by bare name
// Notes: definitions only
`ifndef CTE_CFG_SVH
`define CTE_CFG_SVH

// register byte offsets
`define CTE_OFF_CTRL 12'h000
`define CTE_OFF_STATUS 12'h004
`define CTE_OFF_COUNT 12'h008
`define CTE_OFF_RESULT 12'h00c
`define CTE_OFF_SCAN 12'h010

// control register field positions
`define CTE_CTRL_MODE 0
`define CTE_CTRL_WIDTH 1
`define CTE_CTRL_QMULT 2
`define CTE_CTRL_LATCH 4
`define CTE_CTRL_GATE 5
`define CTE_CTRL_CLEAR 6
`define CTE_CTRL_TICK 8
`define CTE_CTRL_MAP 12
`define CTE_CTRL_EDGE 16

// control reset value: timing mode, 16 bit, mapped channel 1, rising edges
`define CTE_CTRL_RESET 32'h0000_1000

// status register field positions
`define CTE_STAT_VALID 0
`define CTE_STAT_RUN 1
`define CTE_STAT_MODE 2

// this channel's own input; phase b sits on the next odd input
`define CTE_OWN_CHANNEL 2'h0
`define CTE_PHASE_B_CHANNEL 2'h1

// clocks in mhz; a tick of div/48 us, i.e. 20.833 ns, 208.33 ns, 2083.3 ns, 20833 ns
`define CTE_SYS_CLK_MHZ 32'd48
`define CTE_PCLK_MHZ 32'd25
`define CTE_TICK_DIV0 32'd1
`define CTE_TICK_DIV1 32'd10
`define CTE_TICK_DIV2 32'd100
`define CTE_TICK_DIV3 32'd1000

// saturation limits of the two counter widths
`define CTE_MAX16 32'h0000_ffff
`define CTE_MAX32 32'hffff_ffff

`endif

// ---- cte_pkg.sv ----
// Purpose: types shared by the counter channel
// Assumes: cte_cfg.svh holds every number
// Notes: none
package cte_pkg;

    // channel working mode
    typedef enum logic {
        cte_mode_timing,
        cte_mode_encoder
    } cte_mode_t;

    // timing measurement state
    typedef enum logic {
        cte_tm_armed,
        cte_tm_running
    } cte_tstate_t;

    // whole register state of the channel
    typedef struct packed {
        logic [3:0] in_meta;
        logic [3:0] in_sync;
        logic [3:0] in_prev;
        logic strobe_meta;
        logic strobe_sync;
        logic strobe_prev;
        cte_mode_t mode;
        logic width32;
        logic [1:0] qmult;
        logic latch_src;
        logic gate_en;
        logic clear_en;
        logic [1:0] tick_sel;
        logic [1:0] map_sel;
        logic [3:0] edge_pol;
        cte_tstate_t tstate;
        logic [31:0] tick_acc;
        logic [31:0] count;
        logic [31:0] result;
        logic result_valid;
        logic [31:0] scan_data;
        logic [31:0] read_data;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cte_state_t;

endpackage

// ---- cte_counter_channel.sv ----
// Purpose: one counter channel in timing mode or quadrature encoder mode, apb registers
// Assumes: counter inputs and read strobe are asynchronous pins; scan and acquisition pulses
//          come from logic on pclk
// Notes: apb answers with one wait state; all outputs are registered
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`include "cte_cfg.svh"

// Function
// - timing mode counts ticks from own-input edge to following mapped-channel edge.
// - start and stop edge polarity comes from each channel's edge selection bit.
// - latching a timing result clears the counter and rearms for next own edge.
// - tick size selectable among four values derived from 48 MHz.
// - each channel has its own asynchronous read strobe for its count.
// - scans report zero until first interval done, then last completed interval.
// - own-channel edge clears timing counter, mapped-channel edge latches the count.
// - width option selects 16-bit or 32-bit timing counter.
// - timing counts saturate at the selected width's maximum, never wrap.
// - encoder counts 16 or 32 bit with 1X, 2X, 4X modes.
// - at most two encoders with A and B, one encoder with index.
// - encoder counts up while A leads B, down while A lags B.
// - 1X counts A rising, 2X both A edges, 4X all A and B edges.
// - two-bit multiplier field picks 1X, 2X or 4X.
// - latch source is start of scan by default, else mapped-channel edge.
// - gating option counts only while mapped channel is high, else holds.
// - clear option zeroes encoder counter on each mapped-channel rising edge.
// - mapped channel may be any input except the channel itself.
// - acquisition start clears all counters so first scan reports zero.
module cte_counter_channel (
    input wire logic pclk, // apb clock, 25 mhz
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb transfer done
    output logic pslverr, // apb error for unmapped address
    input wire logic [3:0] counter_inputs, // counter input pins, post debounce
    input wire logic scan_begin_pulse, // start of scan, one cycle
    input wire logic acq_start_pulse, // acquisition start, one cycle
    input wire logic read_strobe, // asynchronous read strobe of this channel
    output logic [31:0] scan_data, // value latched into the scan stream
    output logic [31:0] read_data // value taken by the read strobe
);

    cte_pkg::cte_state_t s_reg;
    cte_pkg::cte_state_t s_next;

    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0] qual;

    // per-input edge detection on synchronised levels
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_edge
            assign rise[gi] = s_reg.in_sync[gi] & ~s_reg.in_prev[gi];
            assign fall[gi] = ~s_reg.in_sync[gi] & s_reg.in_prev[gi];
            assign qual[gi] = s_reg.edge_pol[gi] ? fall[gi] : rise[gi];
        end
    endgenerate

    // next-state logic of the whole channel
    always_comb begin
        logic [31:0] modulus;
        logic [31:0] acc_sum;
        logic [1:0] inc;
        logic [31:0] cmax;
        logic [32:0] sum;
        logic own_edge;
        logic map_edge;
        logic map_rise;
        logic map_level;
        logic a_now;
        logic b_now;
        logic step_en;
        logic step_up;
        logic [31:0] ctrl_rd;
        modulus = 32'h0;
        acc_sum = 32'h0;
        inc = 2'h0;
        cmax = `CTE_MAX16;
        sum = 33'h0;
        own_edge = 1'b0;
        map_edge = 1'b0;
        map_rise = 1'b0;
        map_level = 1'b0;
        a_now = 1'b0;
        b_now = 1'b0;
        step_en = 1'b0;
        step_up = 1'b0;
        ctrl_rd = 32'h0;
        s_next = s_reg;

        // two-stage synchronisers, then a delayed copy for edges
        s_next.in_meta = counter_inputs;
        s_next.in_sync = s_reg.in_meta;
        s_next.in_prev = s_reg.in_sync;
        s_next.strobe_meta = read_strobe;
        s_next.strobe_sync = s_reg.strobe_meta;
        s_next.strobe_prev = s_reg.strobe_sync;

        // tick generator: 48 mhz ticks spread over 25 mhz cycles, zero, one or two per cycle
        unique case (s_reg.tick_sel)
            2'h0: modulus = `CTE_PCLK_MHZ * `CTE_TICK_DIV0;
            2'h1: modulus = `CTE_PCLK_MHZ * `CTE_TICK_DIV1;
            2'h2: modulus = `CTE_PCLK_MHZ * `CTE_TICK_DIV2;
            2'h3: modulus = `CTE_PCLK_MHZ * `CTE_TICK_DIV3;
        endcase
        acc_sum = s_reg.tick_acc + `CTE_SYS_CLK_MHZ;
        if (acc_sum >= (modulus << 1)) begin
            inc = 2'h2;
            s_next.tick_acc = acc_sum - (modulus << 1);
        end else if (acc_sum >= modulus) begin
            inc = 2'h1;
            s_next.tick_acc = acc_sum - modulus;
        end else begin
            s_next.tick_acc = acc_sum;
        end

        // width and mapped-channel selections
        cmax = s_reg.width32 ? `CTE_MAX32 : `CTE_MAX16;
        own_edge = qual[`CTE_OWN_CHANNEL];
        map_edge = qual[s_reg.map_sel];
        map_rise = rise[s_reg.map_sel];
        map_level = s_reg.in_sync[s_reg.map_sel];
        a_now = s_reg.in_sync[`CTE_OWN_CHANNEL];
        b_now = s_reg.in_sync[`CTE_PHASE_B_CHANNEL];

        // quadrature step decode
        unique case (s_reg.qmult)
            2'h0: begin
                step_en = rise[`CTE_OWN_CHANNEL];
                step_up = ~b_now;
            end
            2'h1: begin
                step_en = rise[`CTE_OWN_CHANNEL] | fall[`CTE_OWN_CHANNEL];
                step_up = a_now ^ b_now;
            end
            default: begin
                if (rise[`CTE_OWN_CHANNEL] | fall[`CTE_OWN_CHANNEL]) begin
                    step_en = 1'b1;
                    step_up = a_now ^ b_now;
                end else begin
                    step_en = rise[`CTE_PHASE_B_CHANNEL] | fall[`CTE_PHASE_B_CHANNEL];
                    step_up = ~(a_now ^ b_now);
                end
            end
        endcase

        // counting, latching and clearing
        if (acq_start_pulse) begin
            s_next.count = 32'h0;
            s_next.result = 32'h0;
            s_next.result_valid = 1'b0;
            s_next.scan_data = 32'h0;
            s_next.tstate = cte_pkg::cte_tm_armed;
        end else if (s_reg.mode == cte_pkg::cte_mode_timing) begin
            sum = {1'b0, s_reg.count} + {31'h0, inc};
            if (s_reg.tstate == cte_pkg::cte_tm_running && map_edge) begin
                s_next.result = (s_reg.count > cmax) ? cmax : s_reg.count;
                s_next.result_valid = 1'b1;
                s_next.count = 32'h0;
                s_next.tstate = cte_pkg::cte_tm_armed;
            end
            if (own_edge) begin
                s_next.count = 32'h0;
                s_next.tstate = cte_pkg::cte_tm_running;
            end else if (s_reg.tstate == cte_pkg::cte_tm_running && !map_edge) begin
                s_next.count = (sum > {1'b0, cmax}) ? cmax : sum[31:0];
            end
            if (scan_begin_pulse) begin
                s_next.scan_data = s_reg.result;
            end
        end else begin
            if (s_reg.clear_en && map_rise) begin
                s_next.count = 32'h0;
            end else if (step_en && (!s_reg.gate_en || map_level)) begin
                if (step_up) begin
                    s_next.count = (s_reg.count + 32'h1) & cmax;
                end else begin
                    s_next.count = (s_reg.count - 32'h1) & cmax;
                end
            end
            if (s_reg.latch_src ? map_edge : scan_begin_pulse) begin
                s_next.scan_data = s_reg.count & cmax;
            end
        end

        // read strobe takes the scan value on its rising edge
        if (s_reg.strobe_sync && !s_reg.strobe_prev) begin
            s_next.read_data = s_reg.scan_data;
        end

        // apb slave: one wait state, then pready with registered data
        ctrl_rd = 32'h0;
        ctrl_rd[`CTE_CTRL_MODE] = s_reg.mode;
        ctrl_rd[`CTE_CTRL_WIDTH] = s_reg.width32;
        ctrl_rd[`CTE_CTRL_QMULT +: 2] = s_reg.qmult;
        ctrl_rd[`CTE_CTRL_LATCH] = s_reg.latch_src;
        ctrl_rd[`CTE_CTRL_GATE] = s_reg.gate_en;
        ctrl_rd[`CTE_CTRL_CLEAR] = s_reg.clear_en;
        ctrl_rd[`CTE_CTRL_TICK +: 2] = s_reg.tick_sel;
        ctrl_rd[`CTE_CTRL_MAP +: 2] = s_reg.map_sel;
        ctrl_rd[`CTE_CTRL_EDGE +: 4] = s_reg.edge_pol;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        if (psel && penable && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.prdata = 32'h0;
            unique case (paddr)
                `CTE_OFF_CTRL: s_next.prdata = ctrl_rd;
                `CTE_OFF_STATUS: begin
                    s_next.prdata[`CTE_STAT_VALID] = s_reg.result_valid;
                    s_next.prdata[`CTE_STAT_RUN] = (s_reg.tstate == cte_pkg::cte_tm_running);
                    s_next.prdata[`CTE_STAT_MODE] = s_reg.mode;
                end
                `CTE_OFF_COUNT: s_next.prdata = s_reg.count;
                `CTE_OFF_RESULT: s_next.prdata = s_reg.result;
                `CTE_OFF_SCAN: s_next.prdata = s_reg.scan_data;
                default: s_next.pslverr = 1'b1;
            endcase
            if (pwrite) begin
                s_next.prdata = 32'h0;
            end
        end
        // a write lands on the completing edge
        if (psel && penable && s_reg.pready && pwrite && paddr == `CTE_OFF_CTRL) begin
            s_next.mode = cte_pkg::cte_mode_t'(pwdata[`CTE_CTRL_MODE]);
            s_next.width32 = pwdata[`CTE_CTRL_WIDTH];
            s_next.qmult = pwdata[`CTE_CTRL_QMULT +: 2];
            s_next.latch_src = pwdata[`CTE_CTRL_LATCH];
            s_next.gate_en = pwdata[`CTE_CTRL_GATE];
            s_next.clear_en = pwdata[`CTE_CTRL_CLEAR];
            s_next.tick_sel = pwdata[`CTE_CTRL_TICK +: 2];
            // restart the tick phase so a leftover residue from a coarse tick
            // cannot force double steps for thousands of cycles at a fine tick
            s_next.tick_acc = 32'h0;
            s_next.edge_pol = pwdata[`CTE_CTRL_EDGE +: 4];
            if (pwdata[`CTE_CTRL_MAP +: 2] != `CTE_OWN_CHANNEL) begin
                s_next.map_sel = pwdata[`CTE_CTRL_MAP +: 2];
            end
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.map_sel <= 2'(`CTE_CTRL_RESET >> `CTE_CTRL_MAP);
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign scan_data = s_reg.scan_data;
    assign read_data = s_reg.read_data;

endmodule

// ---- cte_counter_channel_properties.sv ----
// Purpose: port assertions for the counter channel
// Assumes: one clock, reset async active low
// Notes: bound below
`timescale 1ns/10ps
module cte_channel_checker (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // direction
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [3:0] counter_inputs, // pins
    input wire logic scan_begin_pulse, // scan start
    input wire logic acq_start_pulse, // acq start
    input wire logic read_strobe, // strobe
    input wire logic [31:0] scan_data, // scan value
    input wire logic [31:0] read_data // strobe value
);
    // single clock domain
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // apb answer timing and decode
    wait_state_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb wait state wrong");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    err_decode_a: assert property (psel && penable && !pready && paddr[1:0] == 2'h0
        |=> pslverr == ($past(paddr) > 12'h010)) else $error("address decode wrong");
    // scan and strobe values
    acq_clear_a: assert property (acq_start_pulse && !scan_begin_pulse |=> scan_data == 0)
        else $error("acquisition start left scan value");
    strobe_copy_a: assert property ($rose(read_strobe) ##1 $stable(scan_data)[*5]
        |-> read_data == scan_data) else $error("strobe did not copy");
    read_hold_a: assert property ((!read_strobe)[*6] |=> $stable(read_data))
        else $error("read value moved without strobe");
    scan_quiet_a: assert property ((!scan_begin_pulse && !acq_start_pulse
        && $stable(counter_inputs))[*5] |=> $stable(scan_data))
        else $error("scan value moved without cause");
    // main scenarios reached
    cover property (scan_begin_pulse ##1 scan_data != 32'h0);
    cover property (pslverr);
    cover property ($rose(read_strobe));
endmodule

bind cte_counter_channel cte_channel_checker cte_channel_checker_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .counter_inputs,
    .scan_begin_pulse, .acq_start_pulse, .read_strobe, .scan_data, .read_data);

// ---- cte_encoder_model.sv ----
// Purpose: encoder and pulse source on the counter pins
// Assumes: pins change just after a clock edge
// Notes: hold sets slow or prompt sources
`timescale 1ns/10ps
module cte_encoder_model (
    input wire logic pclk, // clock
    output logic [3:0] pins // counter pins
);
    initial pins = 4'h0;
    // one pin to a level, then held
    task automatic set_pin(input int idx, input logic v, input int hold);
        @(posedge pclk);
        pins[idx] <= v;
        repeat (hold) @(posedge pclk);
    endtask
    // whole cycles, phase a on pin 0, phase b on pin 1
    task automatic quad(input int n, input logic up, input int hold);
        logic [7:0] seq;
        seq = up ? 8'h78 : 8'hb4;
        for (int i = 0; i < n; i++) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge pclk);
                pins[1:0] <= seq[7 - 2 * s -: 2];
                repeat (hold) @(posedge pclk);
            end
        end
    endtask
endmodule

// ---- test_counter_timing_encoder_modes.sv ----
// Purpose: self-checking bench of the counter channel
// Assumes: 25 mhz pclk, apb master below
// Notes: seed 79
`timescale 1ns/10ps
module test_counter_timing_encoder_modes;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic scan_begin_pulse = 1'b0;
    logic acq_start_pulse = 1'b0;
    logic read_strobe = 1'b0;
    logic [31:0] prdata, scan_data, read_data, rd, res;
    logic pready, pslverr, up, err;
    logic [3:0] pins;
    int failures = 0;
    int comparisons = 0;
    int n;

    always #20 pclk = ~pclk;

    cte_counter_channel cte_counter_channel_inst (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .counter_inputs(pins),
        .scan_begin_pulse, .acq_start_pulse, .read_strobe, .scan_data, .read_data);
    cte_encoder_model cte_encoder_model_inst (.pclk, .pins);

    // verdict and end of run
    task automatic wrap_up();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            wrap_up();
        end
    endtask
    // one-cycle scan or acquisition pulse
    task automatic kick(input logic s);
        @(posedge pclk);
        scan_begin_pulse <= s;
        acq_start_pulse <= !s;
        @(posedge pclk);
        scan_begin_pulse <= 1'b0;
        acq_start_pulse <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    // own edge, n+1 cycles, mapped edge, then read the result
    task automatic meas(input int n, input logic fall);
        cte_encoder_model_inst.set_pin(0, 1'b0, 2);
        cte_encoder_model_inst.set_pin(1, fall, 4);
        cte_encoder_model_inst.set_pin(0, 1'b1, n);
        cte_encoder_model_inst.set_pin(1, !fall, 6);
        apb(1'b0, 12'h00c, 32'h0);
        res = rd;
    endtask
    function automatic int div(input int t);
        return t == 0 ? 1 : t == 1 ? 10 : t == 2 ? 100 : 1000;
    endfunction
    // ticks of 48 mhz over cycles of 25 mhz, within three
    function automatic logic [31:0] near(input logic [31:0] r, input int cyc, input int d);
        int e;
        e = cyc * 48 / (25 * d);
        return (int'(r) - e <= 3 && e - int'(r) <= 3) ? 32'h1 : 32'h0;
    endfunction
    function automatic logic [31:0] enc(input int n, input int q, input logic up);
        int k;
        k = q == 0 ? 1 : q == 1 ? 2 : 4;
        return up ? n * k : -(n * k);
    endfunction

    initial begin
        void'($urandom(79));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl_reset", rd, 32'h0000_1000);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("map_self", rd, 32'h0000_1000);
        kick(1'b1);
        chk("scan_first", scan_data, 32'h0);
        // every tick size, rising and falling stop edges
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, 12'h000, 32'h0000_1000 | (t << 8) | (t[0] ? 32'h0002_0000 : 32'h0));
            n = 20 * div(t) + $urandom_range(15);
            meas(n, t[0]);
            chk("interval", near(res, n + 1, div(t)), 32'h1);
        end
        // long interval in both widths
        for (int w = 0; w < 2; w++) begin
            apb(1'b1, 12'h000, 32'h0000_1000 | (w << 1));
            meas(34300, 1'b0);
            chk("saturate", w ? near(res, 34301, 1) : res, w ? 32'h1 : 32'h0000_ffff);
        end
        apb(1'b0, 12'h004, 32'h0);
        chk("status_valid", rd, 32'h1);
        kick(1'b1);
        chk("scan_last", scan_data, res);
        @(posedge pclk);
        read_strobe <= 1'b1;
        repeat (8) @(posedge pclk);
        read_strobe <= 1'b0;
        chk("strobe", read_data, res);
        kick(1'b0);
        kick(1'b1);
        chk("scan_acq", scan_data, 32'h0);
        // encoder in every multiplier code
        cte_encoder_model_inst.set_pin(0, 1'b0, 2);
        cte_encoder_model_inst.set_pin(1, 1'b0, 2);
        for (int q = 0; q < 4; q++) begin
            apb(1'b1, 12'h000, 32'h0000_2003 | (q << 2));
            kick(1'b0);
            n = 1 + $urandom_range(7);
            up = $urandom_range(1);
            cte_encoder_model_inst.quad(n, up, 2 + $urandom_range(3));
            repeat (4) @(posedge pclk);
            apb(1'b0, 12'h008, 32'h0);
            chk("enc_count", rd, enc(n, q, up));
        end
        // mapped latch, index clear, gate
        apb(1'b1, 12'h000, 32'h0000_201b);
        kick(1'b0);
        cte_encoder_model_inst.quad(3, 1'b1, 2);
        cte_encoder_model_inst.set_pin(2, 1'b1, 6);
        chk("mapped_latch", scan_data, 32'd12);
        apb(1'b1, 12'h000, 32'h0000_204b);
        cte_encoder_model_inst.set_pin(2, 1'b0, 2);
        cte_encoder_model_inst.quad(2, 1'b1, 2);
        cte_encoder_model_inst.set_pin(2, 1'b1, 6);
        apb(1'b0, 12'h008, 32'h0);
        chk("index_clear", rd, 32'h0);
        apb(1'b1, 12'h000, 32'h0000_202b);
        cte_encoder_model_inst.quad(1, 1'b1, 2);
        cte_encoder_model_inst.set_pin(2, 1'b0, 4);
        cte_encoder_model_inst.quad(2, 1'b1, 2);
        apb(1'b0, 12'h008, 32'h0);
        chk("gated_hold", rd, 32'd4);
        wrap_up();
    end
endmodule
